// ---- msfr_config_bank.sv ----
// Filter, sync-capture and range configuration bank on AHB-Lite
`default_nettype none
module msfr_config_bank #(
  parameter int unsigned CLK_HZ = msfr_pkg::CLK_HZ,
  parameter int unsigned PERIOD_32K = CLK_HZ / msfr_pkg::RATE_32K_HZ,
  parameter int unsigned PERIOD_8K  = CLK_HZ / msfr_pkg::RATE_8K_HZ,
  parameter int unsigned PERIOD_1K  = CLK_HZ / msfr_pkg::RATE_1K_HZ
) (
  input  wire logic                 CLK_IN,
  input  wire logic                 RST_B_IN,
  input  wire logic                 HSEL_IN,
  input  wire logic [31:0]          HADDR_IN,
  input  wire logic [1:0]           HTRANS_IN,
  input  wire logic                 HWRITE_IN,
  input  wire logic [2:0]           HSIZE_IN,
  input  wire logic [31:0]          HWDATA_IN,
  input  wire logic                 HREADY_IN,
  output logic [31:0]               HRDATA_OUT,
  output logic                      HREADYOUT_OUT,
  output logic                      HRESP_OUT,
  input  wire logic                 FRAME_SYNC_IN,
  input  wire logic                 FIFO_FULL_IN,
  input  wire logic                 FIFO_WRITE_REQ_IN,
  output logic                      FIFO_WR_EN_OUT,
  output logic                      FIFO_DROP_OLDEST_OUT,
  output logic                      INTERNAL_TICK_OUT,
  output logic                      SAMPLE_TICK_OUT,
  output var msfr_pkg::msfr_rate_e  RATE_OUT,
  output logic [3:0]                FILTER_PATH_OUT,
  output var msfr_pkg::msfr_cfg_s   ACTIVE_CFG_OUT,
  output logic [6:0]                SYNC_DEST_OUT,
  output logic                      SYNC_BIT_OUT
);
  import msfr_pkg::*;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic       acc;
  logic       hit;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic       wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [7:0] filt_q;
  logic [7:0] gyro_q;
  logic [7:0] accel_q;
  logic [7:0] div_q;
  logic [7:0] status;

  assign acc = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign idx = HADDR_IN[IDX_MSB:IDX_LSB];
  assign hit = HADDR_IN[31:IDX_MSB+1] == '0;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      wr_pend_q <= acc && HWRITE_IN && hit;
      wr_idx_q  <= idx;
    end
  end

  // Only the low byte of the word is stored; upper lanes are dropped
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      filt_q  <= FILT_RST;
      gyro_q  <= GYRO_RST;
      accel_q <= ACCEL_RST;
      div_q   <= DIV_RST;
    end else if (wr_pend_q) begin
      if (wr_idx_q == IDX_FILT) begin
        filt_q <= HWDATA_IN[7:0];
      end else if (wr_idx_q == IDX_GYRO) begin
        gyro_q <= HWDATA_IN[7:0] & GYRO_MASK;
      end else if (wr_idx_q == IDX_ACCEL) begin
        accel_q <= HWDATA_IN[7:0] & ACCEL_MASK;
      end else if (wr_idx_q == IDX_RATE_DIV) begin
        div_q <= HWDATA_IN[7:0];
      end
    end
  end

  always_comb begin
    if (!hit) begin
      rd_byte = 8'h00;
    end else if (idx == IDX_FILT) begin
      rd_byte = filt_q;
    end else if (idx == IDX_GYRO) begin
      rd_byte = gyro_q;
    end else if (idx == IDX_ACCEL) begin
      rd_byte = accel_q;
    end else if (idx == IDX_RATE_DIV) begin
      rd_byte = div_q;
    end else if (idx == IDX_STATUS) begin
      rd_byte = status;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Zero wait states; unmapped reads return zero with OKAY
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      HRDATA_OUT    <= 32'h0000_0000;
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT     <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
      if (acc && !HWRITE_IN) begin
        HRDATA_OUT <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------
  // Pending and active settings
  // ---------------------------------------------------------------
  msfr_cfg_s  shadow;
  msfr_cfg_s  act_q;
  logic [7:0] eff_div_q;
  logic       div_en;
  logic       int_tick;
  logic       sample_tick;

  always_comb begin
    shadow.fifo_drop_new = filt_q[FIFO_BIT];
    shadow.sync_sel      = filt_q[SYNC_MSB:SYNC_LSB];
    shadow.lpf_setting   = filt_q[LPF_MSB:LPF_LSB];
    shadow.bypass        = gyro_q[BYP_MSB:BYP_LSB];
    shadow.gyro_range    = gyro_q[RANGE_MSB:RANGE_LSB];
    shadow.accel_range   = accel_q[RANGE_MSB:RANGE_LSB];
  end

  // Swapping only on the sample tick keeps each sample self-consistent
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      act_q     <= '0;
      eff_div_q <= DIV_RST;
    end else if (sample_tick) begin
      act_q     <= shadow;
      eff_div_q <= div_q;
    end
  end

  // ---------------------------------------------------------------
  // Internal rate and output sample rate
  // ---------------------------------------------------------------
  msfr_rate_e       rate;
  logic [3:0]       filt_path;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] int_cnt_q;
  logic [7:0]       sdiv_cnt_q;

  always_comb begin
    if (act_q.bypass != BYP_NONE) begin
      rate = RATE_32K;
    end else if (act_q.lpf_setting == LPF_WIDE_LO ||
                 act_q.lpf_setting == LPF_WIDE_HI) begin
      rate = RATE_8K;
    end else begin
      rate = RATE_1K;
    end
  end

  // Bypass overrides the low-pass setting
  always_comb begin
    if (act_q.bypass[BYP_LSB]) begin
      filt_path = FILT_BYP_WIDE;
    end else if (act_q.bypass[BYP_MSB]) begin
      filt_path = FILT_BYP_MID;
    end else begin
      filt_path = {1'b0, act_q.lpf_setting};
    end
  end

  always_comb begin
    case (rate)
      RATE_32K: period = CNT_W'(PERIOD_32K - 1);
      RATE_8K:  period = CNT_W'(PERIOD_8K - 1);
      default:  period = CNT_W'(PERIOD_1K - 1);
    endcase
  end

  assign div_en = rate == RATE_1K;
  assign int_tick = int_cnt_q == period;
  assign sample_tick = int_tick && (!div_en || sdiv_cnt_q == eff_div_q);

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      int_cnt_q <= '0;
    end else if (int_tick) begin
      int_cnt_q <= '0;
    end else begin
      int_cnt_q <= int_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sdiv_cnt_q <= 8'h00;
    end else if (sample_tick) begin
      sdiv_cnt_q <= 8'h00;
    end else if (int_tick) begin
      sdiv_cnt_q <= sdiv_cnt_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Frame-sync latch
  // ---------------------------------------------------------------
  logic fs_prev_q;
  logic latch_q;
  logic pend_q;
  logic cap_q;
  logic fs_edge;
  logic fs_toggle;

  assign fs_edge = FRAME_SYNC_IN ^ fs_prev_q;
  // Edge in the capture cycle still toggles, so a strobe arriving in the capture cycle is not lost
  assign fs_toggle = fs_edge && (!pend_q || sample_tick);

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      fs_prev_q <= 1'b0;
      latch_q   <= 1'b0;
      pend_q    <= 1'b0;
      cap_q     <= 1'b0;
    end else begin
      fs_prev_q <= FRAME_SYNC_IN;
      latch_q   <= latch_q ^ fs_toggle;
      if (fs_toggle) begin
        pend_q <= 1'b1;
      end else if (sample_tick) begin
        pend_q <= 1'b0;
      end
      if (sample_tick) begin
        cap_q <= latch_q;
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[STAT_CAP]  = cap_q;
    status[STAT_PEND] = pend_q;
    status[STAT_LAT]  = latch_q;
    status[STAT_DIV]  = div_en;
    status[1:0]       = rate;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  for (genvar g = 0; g < SYNC_DESTS; g++) begin : g_dest
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
        SYNC_DEST_OUT[g] <= 1'b0;
      end else begin
        SYNC_DEST_OUT[g] <= act_q.sync_sel == 3'(g + 1);
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SYNC_BIT_OUT         <= 1'b0;
      FIFO_WR_EN_OUT       <= 1'b0;
      FIFO_DROP_OLDEST_OUT <= 1'b0;
    end else begin
      SYNC_BIT_OUT <= (act_q.sync_sel != 3'h0) && cap_q;
      FIFO_WR_EN_OUT <= FIFO_WRITE_REQ_IN &&
                        (!FIFO_FULL_IN || !act_q.fifo_drop_new);
      FIFO_DROP_OLDEST_OUT <= FIFO_WRITE_REQ_IN && FIFO_FULL_IN &&
                              !act_q.fifo_drop_new;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      INTERNAL_TICK_OUT <= 1'b0;
      SAMPLE_TICK_OUT   <= 1'b0;
      RATE_OUT          <= RATE_32K;
      FILTER_PATH_OUT   <= 4'h0;
      ACTIVE_CFG_OUT    <= '0;
    end else begin
      INTERNAL_TICK_OUT <= int_tick;
      SAMPLE_TICK_OUT   <= sample_tick;
      RATE_OUT          <= rate;
      FILTER_PATH_OUT   <= filt_path;
      ACTIVE_CFG_OUT    <= act_q;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  reset_top_bit_a: assert property (
    $rose(RST_B_IN) |-> filt_q[TOP_BIT])
    else $error("Filter top bit not set after reset");
  fifo_drop_new_a: assert property (
    FIFO_WRITE_REQ_IN && FIFO_FULL_IN && act_q.fifo_drop_new |=>
    !FIFO_WR_EN_OUT && !FIFO_DROP_OLDEST_OUT)
    else $error("Full FIFO written under drop policy");
  fifo_overwrite_a: assert property (
    FIFO_WRITE_REQ_IN && FIFO_FULL_IN && !act_q.fifo_drop_new |=>
    FIFO_WR_EN_OUT && FIFO_DROP_OLDEST_OUT)
    else $error("Full FIFO not overwritten");
  sync_hold_a: assert property (
    pend_q && !sample_tick |=> $stable(latch_q))
    else $error("Sync latch toggled twice before capture");
  sync_toggle_a: assert property (
    fs_edge && !pend_q |=> latch_q != $past(latch_q) ##0 pend_q)
    else $error("Sync edge not latched");
  sync_dest_a: assert property (
    act_q.sync_sel == 3'h0 |=> SYNC_DEST_OUT == 7'h00 && !SYNC_BIT_OUT)
    else $error("Sync inserted while disabled");
  bypass_rate_a: assert property (
    act_q.bypass != BYP_NONE |=> RATE_OUT == RATE_32K && FILTER_PATH_OUT[3])
    else $error("Bypass did not override low-pass");
  apply_boundary_a: assert property (!sample_tick |=> $stable(act_q))
    else $error("Settings changed between samples");
  range_apply_a: assert property (sample_tick |=> ##1
    ACTIVE_CFG_OUT.gyro_range == $past(gyro_q[RANGE_MSB:RANGE_LSB], 2))
    else $error("Gyro range not applied at sample tick");
  divider_a: assert property (!div_en |-> (int_tick == sample_tick))
    else $error("Divider active outside settings 1 to 6");

  fifo_full_cov_c: cover property (FIFO_WRITE_REQ_IN && FIFO_FULL_IN);
  sync_capture_c: cover property (pend_q && sample_tick);
  divided_tick_c: cover property (int_tick && !sample_tick);
  rate_8k_c: cover property (RATE_OUT == RATE_8K);
endmodule : msfr_config_bank
`default_nettype wire

// ---- msfr_pkg.sv ----
// Register map, field layout, timing and carrier types of the config bank
`default_nettype none
package msfr_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_RATE_DIV = 8'h19;
  localparam logic [7:0] IDX_FILT     = 8'h1A;
  localparam logic [7:0] IDX_GYRO     = 8'h1B;
  localparam logic [7:0] IDX_ACCEL    = 8'h1C;
  localparam logic [7:0] IDX_STATUS   = 8'h20;
  localparam int unsigned IDX_LSB     = 2;
  localparam int unsigned IDX_MSB     = 9;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned TOP_BIT   = 7;
  localparam int unsigned FIFO_BIT  = 6;
  localparam int unsigned SYNC_MSB  = 5;
  localparam int unsigned SYNC_LSB  = 3;
  localparam int unsigned LPF_MSB   = 2;
  localparam int unsigned LPF_LSB   = 0;
  localparam int unsigned RANGE_MSB = 4;
  localparam int unsigned RANGE_LSB = 3;
  localparam int unsigned BYP_MSB   = 1;
  localparam int unsigned BYP_LSB   = 0;
  localparam logic [7:0] FILT_RST   = 8'h80;
  localparam logic [7:0] GYRO_RST   = 8'h00;
  localparam logic [7:0] ACCEL_RST  = 8'h00;
  localparam logic [7:0] DIV_RST    = 8'h00;
  localparam logic [7:0] GYRO_MASK  = 8'hFB;
  localparam logic [7:0] ACCEL_MASK = 8'hF8;
  localparam int unsigned STAT_CAP  = 7;
  localparam int unsigned STAT_PEND = 6;
  localparam int unsigned STAT_LAT  = 5;
  localparam int unsigned STAT_DIV  = 4;
  localparam logic [2:0] LPF_WIDE_LO = 3'h0;
  localparam logic [2:0] LPF_WIDE_HI = 3'h7;
  localparam logic [1:0] BYP_NONE    = 2'h0;
  localparam logic [3:0] FILT_BYP_WIDE = 4'h8;
  localparam logic [3:0] FILT_BYP_MID  = 4'h9;
  localparam int unsigned SYNC_DESTS = 7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned RATE_32K_HZ = 32_000;
  localparam int unsigned RATE_8K_HZ  = 8_000;
  localparam int unsigned RATE_1K_HZ  = 1_000;
  localparam int unsigned CNT_W       = 18;

  typedef enum logic [1:0] {RATE_32K, RATE_8K, RATE_1K} msfr_rate_e;

  typedef struct packed {
    logic       fifo_drop_new;
    logic [2:0] sync_sel;
    logic [2:0] lpf_setting;
    logic [1:0] bypass;
    logic [1:0] gyro_range;
    logic [1:0] accel_range;
  } msfr_cfg_s;
endpackage : msfr_pkg
`default_nettype wire

// ---- tb_msfr_config_bank.sv ----
// Directed bench for the filter, sync and range configuration bank
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    tests_run++; \
    if ((gt) !== (ex)) begin \
      err_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module tb_msfr_config_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import msfr_pkg::*;
  // ----------------------------------------------------------
  // Short periods keep the run brief
  // ----------------------------------------------------------
  localparam int P32 = 8;
  localparam int P8  = 16;
  localparam int P1  = 32;
  localparam int TMO = 40000;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        ffull = 1'b0;
  logic        freq = 1'b0;
  logic        frame_sync_input = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        wr_en;
  logic        drop;
  logic        int_tick;
  logic        smp_tick;
  msfr_rate_e  rate;
  logic [3:0]  path;
  msfr_cfg_s   act;
  logic [6:0]  dest;
  logic        sbit;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #2 clk = ~clk;
  msfr_config_bank #(
    .PERIOD_32K(P32),
    .PERIOD_8K (P8),
    .PERIOD_1K (P1)
  ) msfr_config_bank_inst (
    .CLK_IN              (clk),
    .RST_B_IN            (rst_b),
    .HSEL_IN             (hsel),
    .HADDR_IN            (haddr),
    .HTRANS_IN           (htrans),
    .HWRITE_IN           (hwrite),
    .HSIZE_IN            (hsize),
    .HWDATA_IN           (hwdata),
    .HREADY_IN           (hready),
    .HRDATA_OUT          (hrdata),
    .HREADYOUT_OUT       (hready),
    .HRESP_OUT           (hresp),
    .FRAME_SYNC_IN       (frame_sync_input),
    .FIFO_FULL_IN        (ffull),
    .FIFO_WRITE_REQ_IN   (freq),
    .FIFO_WR_EN_OUT      (wr_en),
    .FIFO_DROP_OLDEST_OUT(drop),
    .INTERNAL_TICK_OUT   (int_tick),
    .SAMPLE_TICK_OUT     (smp_tick),
    .RATE_OUT            (rate),
    .FILTER_PATH_OUT     (path),
    .ACTIVE_CFG_OUT      (act),
    .SYNC_DEST_OUT       (dest),
    .SYNC_BIT_OUT        (sbit)
  );
  // ----------------------------------------------------------
  // Bus and port tasks
  // ----------------------------------------------------------
  task automatic ahb_cyc(input logic w, input logic [7:0] idx,
                         input logic [7:0] val, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h00_0000, idx, 2'b00};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, val};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb_cyc
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic [31:0] d;
    ahb_cyc(1'b1, idx, val, d);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] idx,
                        input logic [7:0] ex);
    logic [31:0] d;
    ahb_cyc(1'b0, idx, 8'h00, d);
    `CHK(nm, {24'h00_0000, ex}, d);
    `CHK("hresp", 1'b0, hresp);
  endtask : rd_chk
  task automatic wait_tick();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (smp_tick !== 1'b1 && k < 2000);
    `CHK("sample_tick", 1'b1, smp_tick);
  endtask : wait_tick
  task automatic tick_gap(output int n);
    n = 0;
    do @(negedge clk); while (int_tick !== 1'b1 && ++n < 1000);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (int_tick !== 1'b1 && n < 1000);
  endtask : tick_gap
  task automatic per_sample(output int n);
    int k;
    k = 0;
    n = 0;
    wait_tick();
    do begin
      @(negedge clk);
      k++;
      if (int_tick === 1'b1) n++;
    end while (smp_tick !== 1'b1 && k < 2000);
  endtask : per_sample
  task automatic fifo_try(input logic full, input logic ew,
                          input logic ed);
    @(posedge clk);
    ffull <= full;
    freq  <= 1'b1;
    @(posedge clk);
    freq <= 1'b0;
    @(negedge clk);
    `CHK("fifo_wr_en", ew, wr_en);
    `CHK("fifo_drop_oldest", ed, drop);
  endtask : fifo_try
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      err_count++;
      $display("mismatch timeout expected 0 seen 1");
      complete_run();
    end
  end
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    int i;
    int n;
    int eg;
    logic [1:0] byp;
    logic [1:0] gr;
    logic [2:0] lpf;
    logic [2:0] sel;
    logic [6:0] ed;
    logic [3:0] ep;
    msfr_rate_e er;
    msfr_cfg_s ex;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK("rate_reset", RATE_8K, rate);
    rd_chk("filt_reset", IDX_FILT, 8'h80);
    rd_chk("gyro_reset", IDX_GYRO, 8'h00);
    rd_chk("accel_reset", IDX_ACCEL, 8'h00);
    rd_chk("div_reset", IDX_RATE_DIV, 8'h00);
    wr(IDX_GYRO, 8'hFF);
    rd_chk("gyro_rw", IDX_GYRO, 8'hFB);
    wr(IDX_ACCEL, 8'hFF);
    rd_chk("accel_rw", IDX_ACCEL, 8'hF8);
    wr(8'h30, 8'hFF);
    rd_chk("unmapped", 8'h30, 8'h00);
    wr(IDX_FILT, 8'h00);
    rd_chk("filt_clear", IDX_FILT, 8'h00);
    $display("test registers done");
    // Bypass cases first, then every low-pass setting
    for (i = 0; i < 11; i++) begin
      byp = (i < 3) ? 2'(i + 1) : 2'b00;
      lpf = (i < 3) ? 3'(i + 4) : 3'(i - 3);
      gr = 2'(i);
      sel = 3'(i);
      wr(IDX_FILT, {1'b0, i[0], sel, lpf});
      wr(IDX_GYRO, {3'b000, gr, 1'b0, byp});
      wr(IDX_ACCEL, {3'b000, ~gr, 3'b000});
      repeat (3) wait_tick();
      ex = '{i[0], sel, lpf, byp, gr, ~gr};
      er = (byp != 2'b00) ? RATE_32K :
           (lpf == 3'd0 || lpf == 3'd7) ? RATE_8K : RATE_1K;
      ep = byp[0] ? FILT_BYP_WIDE : byp[1] ? FILT_BYP_MID : {1'b0, lpf};
      ed = (sel == 3'd0) ? 7'h00 : 7'(1 << (sel - 3'd1));
      `CHK("active_cfg", ex, act);
      `CHK("rate", er, rate);
      `CHK("filter_path", ep, path);
      `CHK("sync_dest", ed, dest);
      tick_gap(n);
      eg = (er == RATE_32K) ? P32 : (er == RATE_8K) ? P8 : P1;
      `CHK("tick_gap", eg, n);
      fifo_try(1'b0, 1'b1, 1'b0);
      fifo_try(1'b1, ~i[0], ~i[0]);
    end
    $display("test settings done");
    wait_tick();
    wr(IDX_GYRO, 8'h08);
    `CHK("cfg_hold", 2'b10, act.gyro_range);
    repeat (2) wait_tick();
    `CHK("cfg_apply", 2'b01, act.gyro_range);
    wr(IDX_RATE_DIV, 8'h03);
    rd_chk("div_rw", IDX_RATE_DIV, 8'h03);
    repeat (2) wait_tick();
    per_sample(n);
    `CHK("div_at_8k", 1, n);
    wr(IDX_FILT, 8'h2A);
    repeat (2) wait_tick();
    per_sample(n);
    `CHK("div_at_1k", 4, n);
    $display("test divider done");
    // A one-cycle strobe must survive until the next sample
    wait_tick();
    @(posedge clk);
    frame_sync_input <= 1'b1;
    @(posedge clk);
    frame_sync_input <= 1'b0;
    repeat (2) wait_tick();
    `CHK("sync_short", 1'b1, sbit);
    wait_tick();
    `CHK("sync_keep", 1'b1, sbit);
    @(posedge clk);
    frame_sync_input <= 1'b1;
    repeat (2) wait_tick();
    `CHK("sync_again", 1'b0, sbit);
    rd_chk("status", IDX_STATUS, 8'h12);
    $display("test sync done");
    complete_run();
  end
endmodule : tb_msfr_config_bank
`default_nettype wire
